// ==== rtl/ddc_pkg.sv ====
package ddc_pkg;
  // Geometry
  localparam int BANKS      = 8;
  localparam int BANK_W     = 3;
  localparam int ADDR_W     = 14;
  localparam int ROW_W_X8   = 14;
  localparam int ROW_W_X16  = 13;
  localparam int COL_W      = 10;
  localparam int AP_BIT     = 10;
  localparam int DQ_W       = 8;
  // Burst and latency limits
  localparam logic [3:0] BL_SHORT = 4'h4;
  localparam logic [3:0] BL_LONG  = 4'h8;
  localparam logic [2:0] CL_MIN   = 3'h3;
  localparam logic [2:0] CL_MAX   = 3'h7;
  localparam logic [2:0] AL_MAX   = 3'h6;
  localparam logic [3:0] WL_DELTA = 4'h1;
  // Command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS  = 3'h0;
  localparam logic [2:0] CMD_REF  = 3'h1;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_NOP  = 3'h7;
  // Power states
  typedef enum logic [1:0] {
    PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF
  } ddc_pwr_t;
endpackage

// ==== rtl/ddc_row_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
// Open-row table, one entry per bank, registered read
module ddc_row_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int DW    = 14
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  // Write side
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read side
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [DEPTH];  // Row storage

  // Storage needs no reset; open flags live outside
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read port
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ddc_cmd_front.sv ====
`timescale 1ns/100ps
`default_nettype none
module ddc_cmd_front #(
  parameter int  ROW_W = ddc_pkg::ROW_W_X8,
  parameter bit  IS_X16 = 1'b0
) (
  // System clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_sys_rst,
  // Memory pins, asynchronous to i_clk
  input  wire logic                         i_ck,
  input  wire logic                         i_cke,
  input  wire logic                         i_cs_n,
  input  wire logic                         i_ras_n,
  input  wire logic                         i_cas_n,
  input  wire logic                         i_we_n,
  input  wire logic [ddc_pkg::BANK_W-1:0]   i_ba,
  input  wire logic [ddc_pkg::ADDR_W-1:0]   i_addr,
  // Configuration
  input  wire logic                         i_bl8,
  input  wire logic [2:0]                   i_cas_lat,
  input  wire logic [2:0]                   i_add_lat,
  // Command decode results
  output logic                              o_act,
  output logic                              o_rd,
  output logic                              o_wr,
  output logic                              o_pre,
  output logic [ddc_pkg::BANK_W-1:0]        o_bank,
  output logic [ddc_pkg::ADDR_W-1:0]        o_row,
  output logic [ddc_pkg::COL_W-1:0]         o_col,
  output logic                              o_auto_pre,
  output logic [ddc_pkg::ADDR_W-1:0]        o_cur_row,
  // Bank and burst status
  output logic [ddc_pkg::BANKS-1:0]         o_bank_open,
  output logic                              o_burst_act,
  output logic                              o_beat_rise,
  output logic                              o_beat_fall,
  output logic [2:0]                        o_beat_idx,
  output logic                              o_burst_wr,
  // Power and buffer gating
  output logic [1:0]                        o_pwr_state,
  output logic                              o_cmd_buf_en,
  output logic                              o_clk_buf_en,
  output logic                              o_drv_en
);
  // Two-stage synchronisers for every pin
  localparam int PW = 6 + ddc_pkg::BANK_W + ddc_pkg::ADDR_W;
  logic [PW-1:0] pin_s1;        // First stage, read only by stage two
  logic [PW-1:0] pin_s2;        // Safe copy
  logic          ck_d;          // Previous clock level for edge find
  wire  [PW-1:0] pin_raw = {i_ck, i_cke, i_cs_n, i_ras_n, i_cas_n,
                            i_we_n, i_ba, i_addr};

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      ck_d   <= 1'b0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      ck_d   <= pin_s2[PW-1];
    end
  end

  // Unpacked synchronised pins
  wire s_ck   = pin_s2[PW-1];
  wire s_cke  = pin_s2[PW-2];
  wire s_cs_n = pin_s2[PW-3];
  wire [2:0] s_cmd = pin_s2[PW-4 -: 3];
  wire [ddc_pkg::BANK_W-1:0] s_ba = pin_s2[ddc_pkg::ADDR_W +:
                                           ddc_pkg::BANK_W];
  wire [ddc_pkg::ADDR_W-1:0] s_addr = pin_s2[ddc_pkg::ADDR_W-1:0];

  // Rising crossing samples commands; both crossings pace data
  wire ck_rise = s_ck & ~ck_d;
  wire ck_fall = ~s_ck & ck_d;

  // Power state and previous CKE
  ddc_pkg::ddc_pwr_t pwr;
  ddc_pkg::ddc_pwr_t next_pwr;
  logic              cke_q;     // CKE value at last rising crossing

  // Command only counts when awake, selected and CKE held high
  wire awake   = (pwr == ddc_pkg::PWR_ON);
  wire cmd_ok  = ck_rise & awake & cke_q & s_cke & ~s_cs_n;
  wire dec_act = cmd_ok & (s_cmd == ddc_pkg::CMD_ACT);
  wire dec_rd  = cmd_ok & (s_cmd == ddc_pkg::CMD_RD);
  wire dec_wr  = cmd_ok & (s_cmd == ddc_pkg::CMD_WR);
  wire dec_pre = cmd_ok & (s_cmd == ddc_pkg::CMD_PRE);
  wire dec_ref = cmd_ok & (s_cmd == ddc_pkg::CMD_REF);
  wire pre_all = s_addr[ddc_pkg::AP_BIT];

  // Row mask by organisation
  wire [ddc_pkg::ADDR_W-1:0] row_mask = IS_X16 ?
    {{(ddc_pkg::ADDR_W-ddc_pkg::ROW_W_X16){1'b0}},
     {ddc_pkg::ROW_W_X16{1'b1}}} : {ddc_pkg::ADDR_W{1'b1}};
  wire [ddc_pkg::ADDR_W-1:0] row_in = s_addr & row_mask;

  // Open-row table, one word per bank
  ddc_row_mem #(
    .DEPTH (ddc_pkg::BANKS),
    .AW    (ddc_pkg::BANK_W),
    .DW    (ddc_pkg::ADDR_W)
  ) u_rows (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_we      (dec_act),
    .i_waddr   (s_ba),
    .i_wdata   (row_in),
    .i_raddr   (s_ba),
    .o_rdata   (o_cur_row)
  );

  // Per-bank open flags; activate sets, precharge clears
  logic [ddc_pkg::BANKS-1:0] bank_open;
  logic [ddc_pkg::BANKS-1:0] ap_pend;   // Auto precharge after burst
  logic [ddc_pkg::BANK_W-1:0] burst_bank;
  wire burst_end;

  genvar gb;
  generate
    for (gb = 0; gb < ddc_pkg::BANKS; gb++) begin : g_bank
      // A genvar cannot be part-selected, so it is sized by a cast
      wire hit   = (s_ba == ddc_pkg::BANK_W'(gb));
      wire set_o = dec_act & hit;
      wire clr_o = (dec_pre & (pre_all | hit)) |
                   (burst_end & ap_pend[gb]);
      wire set_a = (dec_rd | dec_wr) & hit &
                   s_addr[ddc_pkg::AP_BIT];
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          bank_open[gb] <= 1'b0;
          ap_pend[gb]   <= 1'b0;
        end else begin
          // Activation wins so a fresh row is never dropped
          bank_open[gb] <= set_o | (bank_open[gb] & ~clr_o);
          ap_pend[gb]   <= set_a | (ap_pend[gb] & ~clr_o);
        end
      end
    end
  endgenerate

  // Latencies; write is read minus one
  wire [3:0] rd_lat = {1'b0, i_cas_lat} + {1'b0, i_add_lat};
  wire [3:0] wr_lat = rd_lat - ddc_pkg::WL_DELTA;
  wire [3:0] bl_len = i_bl8 ? ddc_pkg::BL_LONG : ddc_pkg::BL_SHORT;

  // Burst sequencer: latency wait, then two beats per clock
  logic       lat_run;
  logic [3:0] lat_cnt;
  logic [3:0] beats;    // Beats left, counts half cycles
  logic       is_wr;
  logic [2:0] col_lo;   // Starting column, low bits
  logic [2:0] beat_n;

  wire col_cmd   = dec_rd | dec_wr;
  wire lat_done  = lat_run & ck_rise & (lat_cnt <= 4'h1);
  wire beat_tick = (beats != 4'h0) & (ck_rise | ck_fall);
  assign burst_end = beat_tick & (beats == 4'h1);

  // Latency counter, loaded on column command
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lat_run <= 1'b0;
      lat_cnt <= 4'h0;
    end else if (col_cmd) begin
      lat_run <= 1'b1;
      lat_cnt <= dec_wr ? wr_lat : rd_lat;
    end else if (lat_done) begin
      lat_run <= 1'b0;
    end else if (lat_run & ck_rise) begin
      lat_cnt <= lat_cnt - 4'h1;
    end
  end

  // Burst length counter and captured column attributes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      beats      <= 4'h0;
      is_wr      <= 1'b0;
      col_lo     <= 3'h0;
      burst_bank <= '0;
      beat_n     <= 3'h0;
    end else if (col_cmd) begin
      is_wr      <= dec_wr;
      col_lo     <= s_addr[2:0];
      burst_bank <= s_ba;
      beat_n     <= 3'h0;
    end else if (lat_done) begin
      beats  <= bl_len;
      beat_n <= 3'h0;
    end else if (beat_tick) begin
      beats  <= beats - 4'h1;
      beat_n <= beat_n + 3'h1;
    end
  end

  // Sequential wrap inside the 4 or 8 beat block
  wire [2:0] seq_idx = i_bl8 ? (col_lo + beat_n) :
                       {col_lo[2], col_lo[1:0] + beat_n[1:0]};

  // Power state: CKE sampled at rising crossing, except on self refresh exit
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      ddc_pkg::PWR_ON: begin
        if (ck_rise & cke_q & ~s_cke) begin
          if (|bank_open) begin
            next_pwr = ddc_pkg::PWR_ACT_PD;
          end else if (~s_cs_n & (s_cmd == ddc_pkg::CMD_REF)) begin
            next_pwr = ddc_pkg::PWR_SELF;
          end else begin
            next_pwr = ddc_pkg::PWR_PRE_PD;
          end
        end
      end
      ddc_pkg::PWR_PRE_PD, ddc_pkg::PWR_ACT_PD: begin
        if (ck_rise & s_cke) begin
          next_pwr = ddc_pkg::PWR_ON;
        end
      end
      ddc_pkg::PWR_SELF: begin
        // Clock may be stopped: exit needs no clock crossing
        if (s_cke) begin
          next_pwr = ddc_pkg::PWR_ON;
        end
      end
      default: next_pwr = ddc_pkg::PWR_ON;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pwr   <= ddc_pkg::PWR_ON;
      cke_q <= 1'b0;
    end else begin
      pwr <= next_pwr;
      if (ck_rise) begin
        cke_q <= s_cke;
      end
    end
  end

  // Buffer gating per power state
  wire buf_on   = awake & s_cke;
  wire clk_keep = (pwr != ddc_pkg::PWR_SELF);

  // Registered outputs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_act <= 1'b0;
      o_rd  <= 1'b0;
      o_wr  <= 1'b0;
      o_pre <= 1'b0;
      o_bank <= '0;
      o_row  <= '0;
      o_col  <= '0;
      o_auto_pre <= 1'b0;
      o_beat_rise <= 1'b0;
      o_beat_fall <= 1'b0;
      o_beat_idx <= 3'h0;
      o_cmd_buf_en <= 1'b0;
      o_clk_buf_en <= 1'b0;
      o_drv_en <= 1'b0;
    end else begin
      o_act <= dec_act;
      o_rd  <= dec_rd;
      o_wr  <= dec_wr;
      o_pre <= dec_pre;
      o_bank <= s_ba;
      o_row  <= row_in;
      o_col  <= s_addr[ddc_pkg::COL_W-1:0];
      o_auto_pre <= s_addr[ddc_pkg::AP_BIT];
      o_beat_rise <= beat_tick & ck_rise;
      o_beat_fall <= beat_tick & ck_fall;
      o_beat_idx <= seq_idx;
      o_cmd_buf_en <= buf_on;
      o_clk_buf_en <= clk_keep;
      o_drv_en <= buf_on & (beats != 4'h0) & ~is_wr;
    end
  end

  assign o_bank_open = bank_open;
  assign o_burst_act = (beats != 4'h0);
  assign o_burst_wr  = is_wr;
  assign o_pwr_state = pwr;

  // Assertions
  property p_mask;
    @(posedge i_clk) disable iff (i_sys_rst)
      (ck_rise & s_cs_n) |=> !(o_act | o_rd | o_wr | o_pre);
  endproperty
  a_mask: assert property (p_mask) else $error("command passed with cs high");

  property p_act_open;
    @(posedge i_clk) disable iff (i_sys_rst)
      dec_act |=> bank_open[$past(s_ba)];
  endproperty
  a_act_open: assert property (p_act_open) else $error("bank not opened");

  property p_pre_all;
    @(posedge i_clk) disable iff (i_sys_rst)
      (dec_pre & pre_all & ~dec_act) |=> (bank_open == '0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all failed");

  property p_burst_len;
    @(posedge i_clk) disable iff (i_sys_rst)
      (lat_done & ~col_cmd) |=> (beats == bl_len);
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("bad burst length");

  property p_wr_lat;
    @(posedge i_clk) disable iff (i_sys_rst)
      dec_wr |=> (lat_cnt == $past(rd_lat) - 4'h1);
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write latency wrong");

  property p_act_pd;
    @(posedge i_clk) disable iff (i_sys_rst)
      (awake & ck_rise & cke_q & ~s_cke & (|bank_open))
      |=> (pwr == ddc_pkg::PWR_ACT_PD);
  endproperty
  a_act_pd: assert property (p_act_pd) else $error("no active power-down");

  property p_sr_exit;
    @(posedge i_clk) disable iff (i_sys_rst)
      (pwr == ddc_pkg::PWR_SELF && s_cke) |=> (pwr == ddc_pkg::PWR_ON);
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self refresh stuck");

  property p_gate;
    @(posedge i_clk) disable iff (i_sys_rst)
      (pwr != ddc_pkg::PWR_ON) |=> !o_cmd_buf_en;
  endproperty
  a_gate: assert property (p_gate) else $error("buffers on in low power");

  property p_no_cmd_sleep;
    @(posedge i_clk) disable iff (i_sys_rst)
      (!awake) |-> !cmd_ok;
  endproperty
  a_no_cmd_sleep: assert property (p_no_cmd_sleep) else $error("cmd asleep");

  c_read: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    dec_rd ##[1:200] burst_end);
  c_self: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    pwr == ddc_pkg::PWR_SELF);
  c_apd: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    pwr == ddc_pkg::PWR_ACT_PD);
endmodule
`default_nettype wire

// ==== bench/ddc_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Controller stand-in: drives memory clock, enable, command and address
module ddc_ctrl_model (
  // Memory clock and clock enable
  output var logic                       o_ck,
  output var logic                       o_cke,
  // Command pins, active low
  output var logic                       o_cs_n,
  output var logic                       o_ras_n,
  output var logic                       o_cas_n,
  output var logic                       o_we_n,
  // Bank and address
  output var logic [ddc_pkg::BANK_W-1:0] o_ba,
  output var logic [ddc_pkg::ADDR_W-1:0] o_addr
);
  logic ck_run;  // Clock halts low, e.g. during self refresh

  // Pin values at time zero, then a 200 ns memory clock
  initial begin
    ck_run = 1'b1;
    o_ck = 1'b0;
    o_cke = 1'b0;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = 3'h7;
    o_ba = 3'h0;
    o_addr = 14'h0000;
    forever begin
      #100;
      // Only a low phase is held, so no runt high pulse appears
      if (ck_run || o_ck) begin
        o_ck = ~o_ck;
      end
    end
  end

  // Deselected lines change every cycle so stale values never look valid
  always @(posedge o_ck) begin
    #50;
    if (o_cs_n) begin
      flip_lines();
    end
  end

  // Invert all qualifying lines
  task automatic flip_lines();
    {o_ras_n, o_cas_n, o_we_n} = ~{o_ras_n, o_cas_n, o_we_n};
    o_ba = ~o_ba;
    o_addr = ~o_addr;
  endtask

  // One command, set on a falling edge and held one full clock
  task automatic issue(input logic [2:0] cmd, input logic [2:0] ba,
                       input logic [13:0] addr, input logic cke,
                       input logic sel);
    @(negedge o_ck);
    o_cs_n = ~sel;
    {o_ras_n, o_cas_n, o_we_n} = cmd;
    o_ba = ba;
    o_addr = addr;
    o_cke = cke;
    @(negedge o_ck);
    o_cs_n = 1'b1;
    flip_lines();
  endtask

  // Clock enable alone, also usable while the clock is halted
  task automatic set_cke(input logic v);
    o_cke = v;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// Bench: command traffic, bursts and power states through the pins
module tb_top;
  logic        i_clk, i_sys_rst, cfg_bl8;
  logic [2:0]  cfg_cl, cfg_al;
  wire logic   ck, cke, cs_n, ras_n, cas_n, we_n;
  wire logic [2:0]  ba;
  wire logic [13:0] addr;
  logic        act, rd, wr, pre, auto_pre, burst_act, beat_rise, beat_fall;
  logic        burst_wr, cmd_buf_en, clk_buf_en, drv_en, cap_ap, saw_drv;
  logic        act_d;  // Activate seen one cycle ago
  logic [13:0] cap_cur;  // Row table read one cycle after activate
  logic [2:0]  bank, beat_idx, cap_bank, first_idx;
  logic [13:0] row, cur_row, cap_row;
  logic [9:0]  col, cap_col;
  logic [7:0]  bank_open, exp_open;  // Expected open banks kept here
  logic [1:0]  pwr_state;
  int          miscompares, num_checks, n_act, n_pre, beats, rbeats;
  int          lat_seen, ck_rises, cyc, i, old;

  ddc_ctrl_model ddc_ctrl_model_inst (.o_ck(ck), .o_cke(cke),
    .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
    .o_ba(ba), .o_addr(addr));

  ddc_cmd_front ddc_cmd_front_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_ck(ck), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr),
    .i_bl8(cfg_bl8), .i_cas_lat(cfg_cl), .i_add_lat(cfg_al),
    .o_act(act), .o_rd(rd), .o_wr(wr), .o_pre(pre), .o_bank(bank),
    .o_row(row), .o_col(col), .o_auto_pre(auto_pre), .o_cur_row(cur_row),
    .o_bank_open(bank_open), .o_burst_act(burst_act),
    .o_beat_rise(beat_rise), .o_beat_fall(beat_fall),
    .o_beat_idx(beat_idx), .o_burst_wr(burst_wr), .o_pwr_state(pwr_state),
    .o_cmd_buf_en(cmd_buf_en), .o_clk_buf_en(clk_buf_en), .o_drv_en(drv_en));

  // System clock, 40 MHz
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Memory clock rises since the last column command
  always @(posedge ck) ck_rises++;

  // Pulse capture, beat counting and the run's time limit
  always @(posedge i_clk) begin
    cyc++;
    // Table read settles one cycle after the activate pulse
    if (act_d) cap_cur = cur_row;
    act_d = (act === 1'b1);
    if (act === 1'b1) begin
      n_act++;
      cap_bank = bank;
      cap_row = row;
    end
    if (pre === 1'b1) n_pre++;
    if (rd === 1'b1 || wr === 1'b1) begin
      beats = 0;
      rbeats = 0;
      ck_rises = 0;
      saw_drv = 1'b0;
      cap_col = col;
      cap_ap = auto_pre;
    end
    if (beat_rise === 1'b1 || beat_fall === 1'b1) begin
      if (beats == 0) begin
        lat_seen = ck_rises;
        first_idx = beat_idx;
      end
      beats++;
      if (beat_rise === 1'b1) rbeats++;
    end
    if (burst_act === 1'b1 && drv_en === 1'b1) saw_drv = 1'b1;
    // Ceiling well above the roughly 1350 cycles the tests need
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // Value comparison
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One command, then time for the synchronisers and the pulse
  task automatic send(input logic [2:0] cmd, input logic [2:0] b,
                      input logic [13:0] a, input logic ke, input logic sel);
    ddc_ctrl_model_inst.issue(cmd, b, a, ke, sel);
    repeat (16) @(posedge i_clk);
    #2;
  endtask

  // Row activation, selected or masked by chip select
  task automatic act_test(input logic [2:0] b, input logic [13:0] r,
                          input logic sel);
    old = n_act;
    send(ddc_pkg::CMD_ACT, b, r, 1'b1, sel);
    if (sel) exp_open[b] = 1'b1;
    chk("act count", old + sel, n_act);
    if (sel) chk("act bank", b, cap_bank);
    if (sel) chk("act row", r, cap_row);
    if (sel) chk("open row table", r, cap_cur);
    chk("open banks", exp_open, bank_open);
    $display("Test activate done");
  endtask

  // Column access with latency, beat count and autoprecharge checks
  task automatic col_test(input logic [2:0] cmd, input logic [2:0] b,
                          input logic [9:0] c, input logic ap,
                          input logic bl, input logic [2:0] cl,
                          input logic [2:0] al);
    int n, lat, k;
    n = bl ? 8 : 4;
    lat = cl + al - ((cmd == ddc_pkg::CMD_WR) ? 1 : 0);
    @(posedge i_clk);
    #2;
    cfg_bl8 = bl;
    cfg_cl = cl;
    cfg_al = al;
    send(cmd, b, {3'h0, ap, c}, 1'b1, 1'b1);
    for (k = 0; k < 300 && !(beats == n && burst_act === 1'b0); k++)
      @(posedge i_clk);
    #2;
    chk("column", c, cap_col);
    chk("autoprecharge", ap, cap_ap);
    chk("latency", lat, lat_seen);
    chk("beats", n, beats);
    chk("rising beats", n / 2, rbeats);
    chk("write flag", cmd == ddc_pkg::CMD_WR, burst_wr);
    if (bl) chk("first index", c[2:0], first_idx);
    if (cmd == ddc_pkg::CMD_RD) chk("drivers", 1'b1, saw_drv);
    if (ap) exp_open[b] = 1'b0;
    chk("open banks", exp_open, bank_open);
    $display("Test column access done");
  endtask

  // Power state and buffer gating levels
  task automatic pwr_chk(input logic [1:0] st, input logic ce,
                         input logic ke, input logic de);
    chk("power state", st, pwr_state);
    chk("command buffers", ce, cmd_buf_en);
    chk("clock buffers", ke, clk_buf_en);
    chk("drivers", de, drv_en);
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {miscompares, num_checks, n_act, n_pre, beats, rbeats} = '0;
    {lat_seen, ck_rises, cyc} = '0;
    act_d = 1'b0;
    i_sys_rst = 1'b1;
    cfg_bl8 = 1'b1;
    cfg_cl = 3'h3;
    cfg_al = 3'h0;
    exp_open = 8'h00;
    repeat (2) @(posedge i_clk);
    #2;
    i_sys_rst = 1'b0;
    chk("reset open banks", 8'h00, bank_open);
    // Initialization: enable, precharge all, refresh
    ddc_ctrl_model_inst.set_cke(1'b1);
    send(ddc_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b1, 1'b0);
    send(ddc_pkg::CMD_PRE, 3'h0, 14'h0400, 1'b1, 1'b1);
    send(ddc_pkg::CMD_REF, 3'h0, 14'h0000, 1'b1, 1'b1);
    chk("precharge count", 1, n_pre);
    act_test(3'h5, 14'h2abc, 1'b1);
    act_test(3'h2, 14'h1555, 1'b0);
    act_test(3'h2, 14'h0f0f, 1'b1);
    // Every CAS and additive latency, both burst lengths
    for (i = 0; i < 7; i++)
      col_test(ddc_pkg::CMD_RD, 3'h5, 10'h3f5, 1'b0, i[0], 3 + i % 5, i);
    col_test(ddc_pkg::CMD_WR, 3'h5, 10'h002, 1'b0, 1'b0, 3'h4, 3'h2);
    col_test(ddc_pkg::CMD_RD, 3'h2, 10'h016, 1'b1, 1'b1, 3'h7, 3'h6);
    // Single bank precharge with A10 low
    send(ddc_pkg::CMD_PRE, 3'h5, 14'h3bff, 1'b1, 1'b1);
    exp_open[5] = 1'b0;
    chk("open after precharge", exp_open, bank_open);
    // Active power-down; a command during it is refused
    act_test(3'h4, 14'h0123, 1'b1);
    send(ddc_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b0, 1'b0);
    pwr_chk(ddc_pkg::PWR_ACT_PD, 1'b0, 1'b1, 1'b0);
    old = n_act;
    send(ddc_pkg::CMD_ACT, 3'h6, 14'h0042, 1'b0, 1'b1);
    chk("act in power-down", old, n_act);
    send(ddc_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b1, 1'b0);
    // Drivers stay off while no read burst runs
    pwr_chk(ddc_pkg::PWR_ON, 1'b1, 1'b1, 1'b0);
    $display("Test active power-down done");
    // Precharge all, then precharge power-down
    send(ddc_pkg::CMD_PRE, 3'h0, 14'h0400, 1'b1, 1'b1);
    exp_open = 8'h00;
    chk("open after precharge all", exp_open, bank_open);
    send(ddc_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b0, 1'b0);
    pwr_chk(ddc_pkg::PWR_PRE_PD, 1'b0, 1'b1, 1'b0);
    send(ddc_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b1, 1'b0);
    pwr_chk(ddc_pkg::PWR_ON, 1'b1, 1'b1, 1'b0);
    $display("Test precharge power-down done");
    // Self refresh; exit with the memory clock halted
    send(ddc_pkg::CMD_REF, 3'h0, 14'h0000, 1'b0, 1'b1);
    pwr_chk(ddc_pkg::PWR_SELF, 1'b0, 1'b0, 1'b0);
    ddc_ctrl_model_inst.ck_run = 1'b0;
    repeat (40) @(posedge i_clk);
    ddc_ctrl_model_inst.set_cke(1'b1);
    repeat (8) @(posedge i_clk);
    #2;
    chk("self refresh exit", ddc_pkg::PWR_ON, pwr_state);
    ddc_ctrl_model_inst.ck_run = 1'b1;
    $display("Test self refresh done");
    final_report();
  end
endmodule
`default_nettype wire
